// ==== src/irq_prio_defs.svh ====
// offsets, field layout, reset values and write masks of the
// interrupt priority registers; included by the package and the block
`ifndef IRQ_PRIO_DEFS_SVH
`define IRQ_PRIO_DEFS_SVH

// register indices; byte address is four times the index
`define IDX_SERIAL_DECODER1 3'h5
`define IDX_TIMER_DECODER0  3'h6
`define IDX_TIMER_ABC       3'h7
`define REG_COUNT           3

// reset value of every register: all sources disabled
`define PRIO_RESET          16'h0000

// writable bits; reserved pairs stay zero
`define WMASK_SERIAL_DEC1   16'hff3f
`define WMASK_TIMER_DEC0    16'hffcf
`define WMASK_TIMER_ABC     16'hffff

// field geometry and slot count (8 slots per register)
`define FIELD_W             2
`define SLOTS_PER_REG       8
`define NUM_SLOTS           24

// slot of each source: (register - 5) * 8 + field lsb / 2
`define SLOT_SPI0_TX_EMPTY    0
`define SLOT_SERIAL1_TX_EMPTY 1
`define SLOT_SERIAL1_TX_IDLE  2
`define SLOT_SERIAL1_RX_ERROR 4
`define SLOT_SERIAL1_RX_FULL  5
`define SLOT_DECODER1_HOME    6
`define SLOT_DECODER1_INDEX   7
`define SLOT_DECODER0_HOME    8
`define SLOT_DECODER0_INDEX   9
`define SLOT_TIMER_D_CH0      11
`define SLOT_TIMER_D_CH3      14
`define SLOT_TIMER_C_CH0      15
`define SLOT_TIMER_C_CH1      16
`define SLOT_TIMER_C_CH3      18
`define SLOT_TIMER_A_CH0      23

`endif

// ==== src/irq_prio_pkg.sv ====
// types of the interrupt priority register block
// assumes irq_prio_defs.svh on the include path
`include "irq_prio_defs.svh"

package irq_prio_pkg;
	typedef enum logic [1:0] {
		PRIO_OFF = 2'b00,
		PRIO_L0  = 2'b01,
		PRIO_L1  = 2'b10,
		PRIO_L2  = 2'b11
	} prio_code_e;
	typedef logic [15:0] prio_reg_t;
	typedef logic [`NUM_SLOTS-1:0][1:0] level_vec_t;
	typedef logic [`NUM_SLOTS-1:0] slot_vec_t;
endpackage : irq_prio_pkg

// ==== src/irq_priority_level_regs.sv ====
// three interrupt priority registers on an AHB-Lite slave, with
// per-source request gating and level tagging toward the core
// assumes one clock; requests come from logic on that clock
// Behaviour
// R1 - field code 01 gives level 0, 10 level 1, 11 level 2
// R2 - field 00 disables its source; no request reaches the core
// R3 - sources reach only levels zero to two, never the top level
// R4 - reset clears every field to disabled
// R5 - reserved bit pairs read zero and ignore writes
// R6 - fifth register bits 15-14 decoder1 index, 13-12 decoder1 home
// R7 - fifth register bits 11-10 serial1 rx full, 9-8 rx error
// R8 - fifth register 7-6 reserved, 5-4 tx idle, 3-2 tx empty
// R9 - fifth register bits 1-0 spi0 transmitter empty
// R10 - sixth register at index 6; timer c ch0, timer d ch3
// R11 - sixth register 11-10, 9-8, 7-6 timer d channels 2, 1, 0
// R12 - sixth register 5-4 reserved; 3-2 decoder0 index, 1-0 home
// R13 - seventh register at index 7, no reserved bits; timer a ch0
// R14 - seventh register 13-12 down to 7-6 timer b channels 3 to 0
// R15 - seventh register 5-4 timer c ch3, 3-2 timer c ch2
// R16 - fifth register at index 5, resets to zero
// R17 - seventh register bits 1-0 timer c channel 1
// R18 - enabled request goes to the core tagged with its level
// R19 - writes act next cycle; reads return stored fields
`timescale 1ns/1ps
`include "irq_prio_defs.svh"

module irq_priority_level_regs
	import irq_prio_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input  wire logic                clk,
	input  wire logic                arst_n,
	input  wire logic                hsel,
	input  wire logic [ADDR_W-1:0]   haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic                     hreadyout,
	output logic                     hresp,
	output logic [31:0]              hrdata,
	input  wire irq_prio_pkg::slot_vec_t  src_req,
	output irq_prio_pkg::slot_vec_t       fwd_req,
	output irq_prio_pkg::level_vec_t      fwd_level,
	output logic [2:0]               lvl_pending
);
	import irq_prio_pkg::*;

	if (ADDR_W < 5) begin : g_chk
		$error("ADDR_W too small to reach the register words");
	end

	function automatic logic [2:0] reg_decode(
		input logic [ADDR_W-1:0] a
	);
		logic [2:0] sel;
		sel = 3'h0;
		if (a[1:0] == 2'h0 && (a >> 2) == ADDR_W'(`IDX_SERIAL_DECODER1))
			sel = 3'h1;
		if (a[1:0] == 2'h0 && (a >> 2) == ADDR_W'(`IDX_TIMER_DECODER0))
			sel = 3'h2;
		if (a[1:0] == 2'h0 && (a >> 2) == ADDR_W'(`IDX_TIMER_ABC))
			sel = 3'h4;
		return sel;
	endfunction : reg_decode

	function automatic prio_reg_t wmask(input int i);
		case (i)
			0:       return `WMASK_SERIAL_DEC1; // R5 R8
			1:       return `WMASK_TIMER_DEC0; // R5 R12
			default: return `WMASK_TIMER_ABC; // R13
		endcase
	endfunction : wmask

	function automatic logic [1:0] field_level(input logic [1:0] f);
		case (f)
			PRIO_L0: return 2'h0; // R1
			PRIO_L1: return 2'h1; // R1
			PRIO_L2: return 2'h2; // R1 R3
			default: return 2'h0;
		endcase
	endfunction : field_level

	// reset release through two flops; assertion stays asynchronous
	logic rst_s1_r;
	logic rst_n;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_r <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n    <= rst_s1_r;
		end
	end

	// bus pipeline: address phase captured, write applied in data phase
	logic        ap_valid;
	logic [2:0]  ap_sel;
	logic        dp_wr_r;
	logic        dp_wr_nxt;
	logic [2:0]  dp_sel_r;
	logic [2:0]  dp_sel_nxt;
	logic [31:0] hrdata_r;
	logic [31:0] hrdata_nxt;
	prio_reg_t   regs_r   [`REG_COUNT];
	prio_reg_t   regs_nxt [`REG_COUNT];

	always_comb begin
		ap_valid   = hsel && htrans[1] && hready;
		ap_sel     = ap_valid ? reg_decode(haddr) : 3'h0;
		dp_wr_nxt  = ap_valid && hwrite;
		dp_sel_nxt = ap_sel;
		for (int i = 0; i < `REG_COUNT; i++) begin
			regs_nxt[i] = regs_r[i];
			if (dp_wr_r && dp_sel_r[i])
				regs_nxt[i] = hwdata[15:0] & wmask(i); // R5 R19
		end
		// read sees a write still in its data phase; unmapped reads zero
		hrdata_nxt = 32'h0;
		for (int i = 0; i < `REG_COUNT; i++) begin
			if (ap_valid && !hwrite && ap_sel[i])
				hrdata_nxt = {16'h0, regs_nxt[i]}; // R19 R5
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dp_wr_r  <= 1'b0;
			dp_sel_r <= 3'h0;
			hrdata_r <= 32'h0;
			for (int i = 0; i < `REG_COUNT; i++)
				regs_r[i] <= `PRIO_RESET; // R4 R16
		end else begin
			dp_wr_r  <= dp_wr_nxt;
			dp_sel_r <= dp_sel_nxt;
			hrdata_r <= hrdata_nxt;
			for (int i = 0; i < `REG_COUNT; i++)
				regs_r[i] <= regs_nxt[i];
		end
	end

	// zero wait states; every transfer answers OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_r;

	// slot k is register k/8, bits 2*(k%8)+1 : 2*(k%8)
	logic [47:0] all_fields;
	assign all_fields = {regs_r[2], // R13 R14 R15 R17
		regs_r[1], // R10 R11
		regs_r[0]}; // R6 R7 R9

	// request gating; one cycle of latency buys registered outputs
	slot_vec_t  fwd_req_r;
	slot_vec_t  fwd_req_nxt;
	level_vec_t fwd_lvl_r;
	level_vec_t fwd_lvl_nxt;
	logic [2:0] pend_r;
	logic [2:0] pend_nxt;

	for (genvar k = 0; k < `NUM_SLOTS; k++) begin : g_slot
		logic [1:0] fld;
		assign fld = all_fields[2*k+1:2*k];
		always_comb begin
			fwd_req_nxt[k] = src_req[k] && (fld != PRIO_OFF); // R2 R18
			fwd_lvl_nxt[k] = field_level(fld); // R18
		end
	end

	always_comb begin
		pend_nxt = 3'h0;
		for (int k = 0; k < `NUM_SLOTS; k++) begin
			if (fwd_req_nxt[k])
				pend_nxt[fwd_lvl_nxt[k]] = 1'b1; // R18
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fwd_req_r <= '0;
			fwd_lvl_r <= '0;
			pend_r    <= 3'h0;
		end else begin
			fwd_req_r <= fwd_req_nxt;
			fwd_lvl_r <= fwd_lvl_nxt;
			pend_r    <= pend_nxt;
		end
	end

	assign fwd_req     = fwd_req_r;
	assign fwd_level   = fwd_lvl_r;
	assign lvl_pending = pend_r;

	// helper: set by the first write, so reset state can be checked
	logic wrote_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			wrote_r <= 1'b0;
		else if (dp_wr_r)
			wrote_r <= 1'b1;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_r1;
		src_req[`SLOT_DECODER1_INDEX] && all_fields[15:14] != 2'b00
		|=> fwd_req[`SLOT_DECODER1_INDEX] &&
		fwd_level[`SLOT_DECODER1_INDEX] == $past(all_fields[15:14]) - 2'h1;
	endproperty
	a_r1: assert property (p_r1) // R1 R6
		else $error("decoder1 index level does not match its field");

	property p_r2;
		all_fields[`SLOT_TIMER_C_CH1*2 +: 2] == 2'b00
		|=> !fwd_req[`SLOT_TIMER_C_CH1];
	endproperty
	a_r2: assert property (p_r2) // R2 R17
		else $error("disabled source forwarded a request");

	property p_r3;
		src_req[`SLOT_SERIAL1_RX_FULL] &&
		all_fields[`SLOT_SERIAL1_RX_FULL*2 +: 2] == 2'b11
		|=> fwd_level[`SLOT_SERIAL1_RX_FULL] == 2'h2 && lvl_pending[2];
	endproperty
	a_r3: assert property (p_r3) // R3 R7
		else $error("top field code did not give level two");

	property p_r3_lvl;
		fwd_req[`SLOT_TIMER_A_CH0]
		|-> fwd_level[`SLOT_TIMER_A_CH0] != 2'h3 &&
		fwd_level[`SLOT_TIMER_A_CH0] ==
		$past(all_fields[`SLOT_TIMER_A_CH0*2 +: 2]) - 2'h1;
	endproperty
	a_r3_lvl: assert property (p_r3_lvl) // R3 R13
		else $error("source tagged above level two");

	property p_r4;
		!wrote_r |-> regs_r[0] == 16'h0 && regs_r[1] == 16'h0 &&
		regs_r[2] == 16'h0 && fwd_req == '0;
	endproperty
	a_r4: assert property (p_r4) // R4 R16
		else $error("register not cleared before first write");

	property p_r5;
		regs_r[0][7:6] == 2'b00 && regs_r[1][5:4] == 2'b00 &&
		hrdata[31:16] == 16'h0;
	endproperty
	a_r5: assert property (p_r5) // R5 R8 R12
		else $error("reserved bits not zero");

	property p_r16;
		dp_wr_r && dp_sel_r == 3'h1
		|=> regs_r[0] == ($past(hwdata[15:0]) & 16'hff3f);
	endproperty
	a_r16: assert property (p_r16) // R16 R6 R7 R8 R9 R19
		else $error("fifth register write not stored");

	property p_r10;
		dp_wr_r && dp_sel_r == 3'h2
		|=> regs_r[1] == ($past(hwdata[15:0]) & 16'hffcf);
	endproperty
	a_r10: assert property (p_r10) // R10 R11 R12 R19
		else $error("sixth register write not stored");

	property p_r13;
		ap_valid && hwrite && haddr == ADDR_W'(28)
		##1 1'b1 |=> regs_r[2] == $past(hwdata[15:0]);
	endproperty
	a_r13: assert property (p_r13) // R13 R14 R15 R19
		else $error("seventh register write not stored");

	property p_r19;
		ap_valid && !hwrite && reg_decode(haddr) == 3'h2 && !dp_wr_r
		|=> hrdata == {16'h0, $past(regs_r[1])};
	endproperty
	a_r19: assert property (p_r19) // R19
		else $error("read returned a value other than the stored one");

	property p_r18;
		src_req[`SLOT_TIMER_D_CH3] &&
		all_fields[`SLOT_TIMER_D_CH3*2 +: 2] == 2'b11
		|=> fwd_req[`SLOT_TIMER_D_CH3] && lvl_pending[2];
	endproperty
	a_r18: assert property (p_r18) // R18 R10
		else $error("enabled request not raised at its level");

	property p_unmapped;
		ap_valid && !hwrite && reg_decode(haddr) == 3'h0 |=> hrdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read returned nonzero data");

	property p_cov_l2;
		fwd_req[`SLOT_SERIAL1_RX_FULL] && lvl_pending[2];
	endproperty
	c_l2: cover property (p_cov_l2);

	property p_cov_decoder0;
		fwd_req[`SLOT_DECODER0_INDEX] && fwd_req[`SLOT_DECODER0_HOME];
	endproperty
	c_decoder0: cover property (p_cov_decoder0);

	property p_cov_rw;
		dp_wr_r && dp_sel_r == 3'h4 ##1 ap_valid && !hwrite;
	endproperty
	c_rw: cover property (p_cov_rw);

	property p_cov_all_lvls;
		lvl_pending == 3'h7;
	endproperty
	c_all_lvls: cover property (p_cov_all_lvls);

	// unused by the logic: only whole-word transfers are expected
	logic unused_size;
	assign unused_size = ^{hsize, src_req[3], src_req[10],
		fwd_req[`SLOT_SPI0_TX_EMPTY], fwd_req[`SLOT_SERIAL1_TX_EMPTY],
		fwd_req[`SLOT_SERIAL1_TX_IDLE], fwd_req[`SLOT_SERIAL1_RX_ERROR],
		fwd_req[`SLOT_DECODER1_HOME], fwd_req[`SLOT_TIMER_D_CH0],
		fwd_req[`SLOT_TIMER_C_CH0], fwd_req[`SLOT_TIMER_C_CH3]};

endmodule : irq_priority_level_regs

// ==== verification/src_model.sv ====
// request side model: peripheral sources raising level requests
// assumes the bench says which sources assert; one clock domain
`timescale 1ns/1ps

module src_model (
	input  wire logic                    clk,
	input  wire irq_prio_pkg::slot_vec_t want,
	output irq_prio_pkg::slot_vec_t      src_req
);
	import irq_prio_pkg::*;

	// registered like real peripheral flags, so one cycle late
	always_ff @(posedge clk) begin
		src_req <= want;
	end
endmodule : src_model

// ==== verification/tb_irq_priority_level_regs.sv ====
// bench of the priority register block: bus access and gating
// assumes the block is the only slave; hready tied to hreadyout
`timescale 1ns/1ps

module tb_irq_priority_level_regs;
	import irq_prio_pkg::*;

	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [11:0] haddr = '0;
	logic [1:0]  htrans = '0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = '0;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic        hreadyout;
	logic        hresp;
	slot_vec_t   want = '0;
	slot_vec_t   src_req;
	slot_vec_t   fwd_req;
	level_vec_t  fwd_level;
	logic [2:0]  lvl_pending;
	int          failures = 0;
	int          num_checks = 0;

	always #10 clk = ~clk;

	irq_priority_level_regs #(.ADDR_W(12)) irq_priority_level_regs_inst (
		.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .src_req(src_req),
		.fwd_req(fwd_req), .fwd_level(fwd_level),
		.lvl_pending(lvl_pending)
	);

	src_model src_model_inst (.clk(clk), .want(want), .src_req(src_req));

	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// single word transfer; waits on hready, never on a fixed count
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		rd = hrdata;
		chk(48'(hresp), 48'h0);
	endtask : xfer

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(48'(rd), 48'(exp));
	endtask : rdchk

	task automatic do_reset();
		arst_n <= 1'b0;
		@(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
	endtask : do_reset

	task automatic t_reset();
		rdchk(12'h014, 32'h0);
		rdchk(12'h018, 32'h0);
		rdchk(12'h01c, 32'h0);
		rdchk(12'h020, 32'h0);
		$display("done reset values");
	endtask : t_reset

	// reserved pairs hold zero; a stray write elsewhere changes nothing
	task automatic t_mask();
		for (int r = 0; r < 3; r++) begin
			xfer(1'b1, 12'(12'h014 + 4 * r), 32'hffffffff);
		end
		xfer(1'b1, 12'h020, 32'h0);
		rdchk(12'h014, 32'h0000ff3f);
		rdchk(12'h018, 32'h0000ffcf);
		rdchk(12'h01c, 32'h0000ffff);
		do_reset();
		rdchk(12'h014, 32'h0);
		rdchk(12'h01c, 32'h0);
		$display("done masks and reset");
	endtask : t_mask

	// one slot enabled at a time, codes 01 10 11 in turn
	task automatic t_slots();
		int          c;
		logic [31:0] v;
		logic        res;
		want <= '1;
		for (int k = 0; k < 24; k++) begin
			c = k % 3 + 1;
			res = (k == 3) || (k == 10);
			v = 32'(c) << (2 * (k % 8));
			for (int r = 0; r < 3; r++) begin
				xfer(1'b1, 12'(12'h014 + 4 * r), (r == k / 8) ? v : 32'h0);
			end
			repeat (3) @(posedge clk);
			chk(48'(fwd_req), res ? 48'h0 : 48'h1 << k);
			chk(48'(fwd_level[k]), res ? 48'h0 : 48'(c - 1));
			chk(48'(lvl_pending), res ? 48'h0 : 48'h1 << (c - 1));
			rdchk(12'(12'h014 + 4 * (k / 8)), res ? 32'h0 : v);
		end
		want <= '0;
		repeat (3) @(posedge clk);
		chk(48'(fwd_req), 48'h0);
		want <= '1;
		xfer(1'b1, 12'h01c, 32'h0);
		rdchk(12'h01c, 32'h0);
		repeat (3) @(posedge clk);
		chk(48'(fwd_req), 48'h0);
		chk(48'(fwd_level), 48'h0);
		// three sources at once, one on each level
		xfer(1'b1, 12'h018, 32'h0000c009);
		repeat (3) @(posedge clk);
		chk(48'(fwd_req), 48'h000000008300);
		chk(48'(fwd_level), 48'h000080040000);
		chk(48'(lvl_pending), 48'h7);
		$display("done slot mapping");
	endtask : t_slots

	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_sim

	initial begin
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_mask();
		t_slots();
		end_sim();
	end

	// whole run is a few hundred cycles
	initial begin
		#(20 * 20000);
		failures++;
		end_sim();
	end
endmodule : tb_irq_priority_level_regs
